/* File: logic/twb_pkg.sv */
/*
  shared constants and types for both ends of the two-wire bus engine.
  assumes a 250 MHz system clock and open-drain lines resolved by twb_if.
*/
`default_nettype none
package twb_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ     = 250;
  localparam int GLITCH_NS   = 50;
  localparam int FILT_CYC    = (GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int SCL_HALF_NS = 1250;
  localparam int HALF_CYC    = (SCL_HALF_NS * CLK_MHZ) / 1000;
  localparam logic [3:0] FILT_LAST = 4'(FILT_CYC - 1);
  localparam logic [9:0] HALF_LAST = 10'(HALF_CYC - 1);
  // ----------------------------------------
  // packet fields and reset levels
  // ----------------------------------------
  localparam logic [6:0] GC_ADDR   = 7'h00;
  localparam logic [3:0] RSV_HI    = 4'hf;
  localparam logic [7:0] GC_READ   = 8'h01;
  localparam logic [3:0] BIT_ACK   = 4'h8;
  localparam logic [3:0] BIT_END   = 4'h9;
  localparam logic [8:0] TXM_WR    = 9'h1fe;
  localparam logic [8:0] TXM_RD    = 9'h001;
  localparam logic       LINE_REL  = 1'b1;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    twb_op_start = 2'b00,
    twb_op_write = 2'b01,
    twb_op_read  = 2'b10,
    twb_op_stop  = 2'b11
  } twb_op_t;
  typedef enum logic [2:0] {
    twb_s_idle = 3'b000,
    twb_s_addr = 3'b001,
    twb_s_rx   = 3'b010,
    twb_s_tx   = 3'b011,
    twb_s_ign  = 3'b100
  } twb_sl_st_t;
endpackage
`default_nettype wire

/* File: logic/twb_if.sv */
/*
  shared scl/sda lines with one modport per end.
  assumes open-drain drivers: a line is low if any enabled driver is low.
*/
`timescale 1ns/1ps
`default_nettype none
interface twb_if;
  logic scl;
  logic sda;
  logic dev_scl_o;
  logic dev_scl_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic far_scl_o;
  logic far_scl_oe_n;
  logic far_sda_o;
  logic far_sda_oe_n;
  // ----------------------------------------
  // wired-and resolution with pull-up
  // ----------------------------------------
  assign scl = (dev_scl_oe_n | dev_scl_o) & (far_scl_oe_n | far_scl_o);
  assign sda = (dev_sda_oe_n | dev_sda_o) & (far_sda_oe_n | far_sda_o);
  modport dev (input scl, input sda, output dev_scl_o, output dev_scl_oe_n,
               output dev_sda_o, output dev_sda_oe_n);
  modport far (input scl, input sda, output far_scl_o, output far_scl_oe_n,
               output far_sda_o, output far_sda_oe_n);
endinterface
`default_nettype wire

/* File: logic/twb_far_end.sv */
/*
  far end: a plain slave on the shared bus with clock stretching.
  assumes the device end or another master makes scl and start/stop.
*/
`timescale 1ns/1ps
`default_nettype none
module twb_far_end (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  twb_if.far              bus,
  input  wire logic [6:0] far_addr,
  input  wire logic       gc_en,
  input  wire logic       ack_en,
  input  wire logic       stretch_req,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_take,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            addr_match,
  output logic            bus_busy
);
  typedef struct packed {
    logic scl_s1; logic scl_s2; logic sda_s1; logic sda_s2;
    logic scl_p; logic sda_p; logic busy;
    twb_pkg::twb_sl_st_t st;
    logic [3:0] bit_n; logic [7:0] sh; logic [7:0] tx;
    logic low; logic wait_tx; logic hold; logic rw; logic mack;
    logic tx_take; logic rx_valid; logic [7:0] rx_data; logic match;
    logic scl_oe_n; logic sda_oe_n;
  } twb_far_t;
  twb_far_t r;
  twb_far_t v;
  logic rise;
  logic fall;
  logic st_ev;
  logic sp_ev;
  logic hit;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    v = r;
    v.scl_s1 = bus.scl;
    v.scl_s2 = r.scl_s1;
    v.sda_s1 = bus.sda;
    v.sda_s2 = r.sda_s1;
    v.scl_p = r.scl_s2;
    v.sda_p = r.sda_s2;
    rise = r.scl_s2 & ~r.scl_p;
    fall = ~r.scl_s2 & r.scl_p;
    st_ev = r.scl_s2 & r.scl_p & r.sda_p & ~r.sda_s2;
    sp_ev = r.scl_s2 & r.scl_p & ~r.sda_p & r.sda_s2;
    hit = ack_en & ((r.sh[7:1] == far_addr) |
          (gc_en & (r.sh[7:1] == twb_pkg::GC_ADDR) & ~r.sh[0]));
    v.rx_valid = 1'b0;
    v.tx_take = 1'b0;
    if (st_ev) begin
      v.busy = 1'b1;
      v.st = twb_pkg::twb_s_addr;
      v.bit_n = 4'h0;
      v.low = 1'b0;
      v.wait_tx = 1'b0;
      v.match = 1'b0;
    end else if (sp_ev) begin
      v.busy = 1'b0;
      v.st = twb_pkg::twb_s_idle;
      v.low = 1'b0;
      v.wait_tx = 1'b0;
      v.match = 1'b0;
    end else if (r.st != twb_pkg::twb_s_idle && r.st != twb_pkg::twb_s_ign) begin
      if (rise) begin
        if (r.bit_n == twb_pkg::BIT_ACK) begin
          v.mack = r.sda_s2;
        end else begin
          v.sh = {r.sh[6:0], r.sda_s2};
        end
        v.bit_n = 4'(r.bit_n + 4'h1);
      end
      if (fall) begin
        // sda only moves while scl is low
        if (r.bit_n == twb_pkg::BIT_ACK) begin
          case (r.st)
            twb_pkg::twb_s_addr: begin
              if (hit) begin
                v.match = 1'b1;
                v.rw = r.sh[0];
                v.low = 1'b1;
              end else begin
                v.st = twb_pkg::twb_s_ign;
              end
            end
            twb_pkg::twb_s_rx: begin
              v.rx_valid = 1'b1;
              v.rx_data = r.sh;
              v.low = ack_en;
            end
            default: v.low = 1'b0;
          endcase
        end else if (r.bit_n == twb_pkg::BIT_END) begin
          v.bit_n = 4'h0;
          v.low = 1'b0;
          if ((r.st == twb_pkg::twb_s_addr && r.rw) ||
              (r.st == twb_pkg::twb_s_tx && !r.mack)) begin
            v.st = twb_pkg::twb_s_tx;
            v.wait_tx = 1'b1;
          end else if (r.st == twb_pkg::twb_s_tx) begin
            v.st = twb_pkg::twb_s_ign;
          end else begin
            v.st = twb_pkg::twb_s_rx;
          end
        end else if (r.st == twb_pkg::twb_s_tx) begin
          v.low = ~r.tx[6];
          v.tx = {r.tx[6:0], 1'b1};
        end
        if (stretch_req) begin
          v.hold = 1'b1;
        end
      end
    end
    if (!stretch_req) begin
      v.hold = 1'b0;
    end
    if (r.wait_tx && tx_valid) begin
      v.wait_tx = 1'b0;
      v.tx = tx_data;
      v.low = ~tx_data[7];
      v.tx_take = 1'b1;
    end
    // scl is only ever held low here, never clocked
    // release scl one cycle after the first sda level is set
    v.scl_oe_n = ~(v.wait_tx | r.wait_tx | v.hold);
    v.sda_oe_n = ~v.low;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.scl_s1 <= twb_pkg::LINE_REL;
      r.scl_s2 <= twb_pkg::LINE_REL;
      r.sda_s1 <= twb_pkg::LINE_REL;
      r.sda_s2 <= twb_pkg::LINE_REL;
      r.scl_p <= twb_pkg::LINE_REL;
      r.sda_p <= twb_pkg::LINE_REL;
      r.scl_oe_n <= twb_pkg::LINE_REL;
      r.sda_oe_n <= twb_pkg::LINE_REL;
    end else begin
      r <= v;
    end
  end

  assign bus.far_scl_o = 1'b0;
  assign bus.far_sda_o = 1'b0;
  assign bus.far_scl_oe_n = r.scl_oe_n;
  assign bus.far_sda_oe_n = r.sda_oe_n;
  assign tx_take = r.tx_take;
  assign rx_valid = r.rx_valid;
  assign rx_data = r.rx_data;
  assign addr_match = r.match;
  assign bus_busy = r.busy;
endmodule
`default_nettype wire

/* File: logic/twb_dev_end.sv */
/*
  device end: two-wire bus master with arbitration plus address-matching slave.
  assumes open-drain lines through twb_if and a user that sequences commands.
*/
`timescale 1ns/1ps
`default_nettype none
module twb_dev_end (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  twb_if.dev              bus,
  input  wire logic       cmd_valid,
  input  wire logic [1:0] cmd_op,
  input  wire logic [7:0] cmd_data,
  input  wire logic       cmd_nack,
  output logic            cmd_ready,
  output logic            rsp_valid,
  output logic [7:0]      rsp_data,
  output logic            rsp_nack,
  output logic            arb_lost,
  input  wire logic [6:0] own_addr,
  input  wire logic       gc_en,
  input  wire logic       ack_en,
  input  wire logic [7:0] sl_tx_data,
  input  wire logic       sl_tx_valid,
  output logic            sl_tx_take,
  output logic            sl_rx_valid,
  output logic [7:0]      sl_rx_data,
  output logic            sl_match,
  output logic            sl_rw,
  output logic            sl_gcall,
  output logic            bus_busy,
  output logic            start_seen,
  output logic            stop_seen
);
  typedef enum logic [3:0] {
    twb_m_idle  = 4'b0000,
    twb_m_start = 4'b0001,
    twb_m_low   = 4'b0010,
    twb_m_high  = 4'b0011,
    twb_m_hold  = 4'b0100,
    twb_m_rs1   = 4'b0101,
    twb_m_rs2   = 4'b0110,
    twb_m_stop1 = 4'b0111,
    twb_m_stop2 = 4'b1000,
    twb_m_stop3 = 4'b1001
  } twb_m_st_t;

  typedef struct packed {
    logic scl_s1; logic scl_s2; logic sda_s1; logic sda_s2;
    logic [4:0] scl_fl; logic [4:0] sda_fl;
    logic scl_p; logic sda_p; logic busy; logic start_seen; logic stop_seen;
    twb_m_st_t m_st;
    logic [9:0] m_cnt; logic [3:0] m_bit;
    logic [8:0] m_sh; logic [8:0] m_txm; logic [8:0] m_rx;
    logic m_sda; logic m_scl; logic m_adr; logic m_anack; logic m_nodata;
    logic cmd_ready; logic rsp_valid; logic [7:0] rsp_data; logic rsp_nack;
    logic arb_lost;
    twb_pkg::twb_sl_st_t s_st;
    logic [3:0] s_bit; logic [7:0] s_sh; logic [7:0] s_tx;
    logic s_low; logic s_wait; logic s_mack;
    logic sl_rx_valid; logic [7:0] sl_rx_data; logic sl_match; logic sl_rw;
    logic sl_gcall; logic sl_tx_take;
    logic scl_oe_n; logic sda_oe_n;
  } twb_dev_t;

  twb_dev_t r;
  twb_dev_t v;

  // ----------------------------------------
  // spike filter: a new level must persist
  // ----------------------------------------
  function automatic logic [4:0] filt(input logic in, input logic [4:0] st);
    logic [4:0] o;
    o = st;
    if (in == st[4]) begin
      o[3:0] = 4'h0;
    end else if (st[3:0] == twb_pkg::FILT_LAST) begin
      o = {in, 4'h0};
    end else begin
      o[3:0] = 4'(st[3:0] + 4'h1);
    end
    return o;
  endfunction

  logic       scl_f;
  logic       sda_f;
  logic       rise;
  logic       fall;
  logic       st_ev;
  logic       sp_ev;
  logic       hdone;
  logic [9:0] cnt_nxt;
  logic       take;
  logic       hit;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    v = r;
    v.scl_s1 = bus.scl;
    v.scl_s2 = r.scl_s1;
    v.sda_s1 = bus.sda;
    v.sda_s2 = r.sda_s1;
    v.scl_fl = filt(r.scl_s2, r.scl_fl);
    v.sda_fl = filt(r.sda_s2, r.sda_fl);
    scl_f = r.scl_fl[4];
    sda_f = r.sda_fl[4];
    v.scl_p = scl_f;
    v.sda_p = sda_f;
    rise = scl_f & ~r.scl_p;
    fall = ~scl_f & r.scl_p;
    st_ev = scl_f & r.scl_p & r.sda_p & ~sda_f;
    sp_ev = scl_f & r.scl_p & ~r.sda_p & sda_f;
    v.start_seen = st_ev;
    v.stop_seen = sp_ev;
    if (st_ev) begin
      v.busy = 1'b1;
    end else if (sp_ev) begin
      v.busy = 1'b0;
    end
    hdone = (r.m_cnt == twb_pkg::HALF_LAST);
    cnt_nxt = hdone ? 10'h000 : 10'(r.m_cnt + 10'h001);
    take = cmd_valid & r.cmd_ready;
    v.rsp_valid = 1'b0;
    v.arb_lost = 1'b0;
    v.sl_rx_valid = 1'b0;
    v.sl_tx_take = 1'b0;

    // ----------------------------------------
    // master
    // ----------------------------------------
    case (r.m_st)
      twb_m_idle: begin
        v.m_scl = 1'b1;
        v.m_sda = 1'b1;
        if (take && cmd_op == twb_pkg::twb_op_start && cmd_data != twb_pkg::GC_READ) begin
          v.m_sh = {cmd_data, 1'b1};
          v.m_txm = twb_pkg::TXM_WR;
          v.m_adr = 1'b1;
          v.m_sda = 1'b0;
          v.m_cnt = 10'h000;
          v.m_st = twb_m_start;
        end
      end
      twb_m_start: begin
        v.m_cnt = cnt_nxt;
        if (hdone) begin
          v.m_scl = 1'b0;
          v.m_bit = 4'h0;
          v.m_st = twb_m_low;
        end
      end
      twb_m_low: begin
        v.m_scl = 1'b0;
        if (!scl_f) begin
          if (r.m_cnt == 10'h000) begin
            v.m_sda = r.m_sh[8];
          end
          v.m_cnt = cnt_nxt;
          if (hdone) begin
            v.m_scl = 1'b1;
            v.m_st = twb_m_high;
          end
        end
      end
      twb_m_high: begin
        if (scl_f && r.m_cnt == 10'h000 && r.m_txm[8] && r.m_sda && !sda_f) begin
          v.m_st = twb_m_idle;
          v.m_scl = 1'b1;
          v.m_sda = 1'b1;
          v.m_cnt = 10'h000;
          v.arb_lost = 1'b1;
        end else if (scl_f || r.m_cnt != 10'h000) begin
          if (scl_f && r.m_cnt == 10'h000) begin
            v.m_rx = {r.m_rx[7:0], sda_f};
          end
          v.m_cnt = scl_f ? cnt_nxt : 10'h000;
          if (!scl_f || hdone) begin
            v.m_cnt = 10'h000;
            v.m_scl = 1'b0;
            v.m_sh = {r.m_sh[7:0], 1'b1};
            v.m_txm = {r.m_txm[7:0], 1'b0};
            v.m_bit = 4'(r.m_bit + 4'h1);
            v.m_st = twb_m_low;
            if (r.m_bit == twb_pkg::BIT_ACK) begin
              v.m_st = twb_m_hold;
              v.rsp_valid = 1'b1;
              v.rsp_data = v.m_rx[8:1];
              v.rsp_nack = v.m_rx[0];
              v.m_nodata = r.m_adr;
              if (r.m_adr) begin
                v.m_anack = v.m_rx[0];
              end
              v.m_adr = 1'b0;
            end
          end
        end
      end
      twb_m_hold: begin
        v.m_scl = 1'b0;
        if (take) begin
          v.m_cnt = 10'h000;
          v.m_bit = 4'h0;
          case (cmd_op)
            twb_pkg::twb_op_start: begin
              if (cmd_data != twb_pkg::GC_READ) begin
                v.m_sh = {cmd_data, 1'b1};
                v.m_txm = twb_pkg::TXM_WR;
                v.m_adr = 1'b1;
                v.m_sda = 1'b1;
                v.m_st = twb_m_rs1;
              end
            end
            twb_pkg::twb_op_write: begin
              if (!r.m_anack) begin
                v.m_sh = {cmd_data, 1'b1};
                v.m_txm = twb_pkg::TXM_WR;
                v.m_st = twb_m_low;
              end
            end
            twb_pkg::twb_op_read: begin
              if (!r.m_anack) begin
                v.m_sh = {8'hff, cmd_nack};
                v.m_txm = twb_pkg::TXM_RD;
                v.m_st = twb_m_low;
              end
            end
            default: begin
              if (r.m_anack || !r.m_nodata) begin
                v.m_sda = 1'b0;
                v.m_st = twb_m_stop1;
              end
            end
          endcase
        end
      end
      twb_m_rs1: begin
        v.m_cnt = cnt_nxt;
        if (hdone) begin
          v.m_scl = 1'b1;
          v.m_st = twb_m_rs2;
        end
      end
      twb_m_rs2: begin
        if (scl_f) begin
          v.m_cnt = cnt_nxt;
          if (hdone) begin
            v.m_sda = 1'b0;
            v.m_anack = 1'b0;
            v.m_st = twb_m_start;
          end
        end
      end
      twb_m_stop1: begin
        v.m_cnt = cnt_nxt;
        if (hdone) begin
          v.m_scl = 1'b1;
          v.m_st = twb_m_stop2;
        end
      end
      twb_m_stop2: begin
        if (scl_f) begin
          v.m_cnt = cnt_nxt;
          if (hdone) begin
            v.m_sda = 1'b1;
            v.m_st = twb_m_stop3;
          end
        end
      end
      twb_m_stop3: begin
        v.m_cnt = cnt_nxt;
        if (hdone) begin
          v.m_anack = 1'b0;
          v.m_nodata = 1'b0;
          v.m_st = twb_m_idle;
        end
      end
      default: v.m_st = twb_m_idle;
    endcase

    // ----------------------------------------
    // slave, also taken over after a lost arbitration
    // ----------------------------------------
    hit = ack_en & (((r.s_sh[7:1] == own_addr) & (own_addr[6:3] != twb_pkg::RSV_HI)) |
          (gc_en & (r.s_sh[7:1] == twb_pkg::GC_ADDR) & ~r.s_sh[0]));
    if (st_ev) begin
      v.s_st = twb_pkg::twb_s_addr;
      v.s_bit = 4'h0;
      v.s_low = 1'b0;
      v.s_wait = 1'b0;
      v.sl_match = 1'b0;
    end else if (sp_ev) begin
      v.s_st = twb_pkg::twb_s_idle;
      v.s_low = 1'b0;
      v.s_wait = 1'b0;
      v.sl_match = 1'b0;
    end else if (r.s_st != twb_pkg::twb_s_idle && r.s_st != twb_pkg::twb_s_ign) begin
      if (rise) begin
        if (r.s_bit == twb_pkg::BIT_ACK) begin
          v.s_mack = sda_f;
        end else begin
          v.s_sh = {r.s_sh[6:0], sda_f};
        end
        v.s_bit = 4'(r.s_bit + 4'h1);
      end
      if (fall) begin
        if (r.s_bit == twb_pkg::BIT_ACK) begin
          case (r.s_st)
            twb_pkg::twb_s_addr: begin
              if (hit) begin
                v.sl_match = 1'b1;
                v.sl_rw = r.s_sh[0];
                v.sl_gcall = (r.s_sh[7:1] == twb_pkg::GC_ADDR);
                v.s_low = 1'b1;
              end else begin
                v.s_st = twb_pkg::twb_s_ign;
              end
            end
            twb_pkg::twb_s_rx: begin
              v.sl_rx_valid = 1'b1;
              v.sl_rx_data = r.s_sh;
              v.s_low = ack_en;
            end
            default: v.s_low = 1'b0;
          endcase
        end else if (r.s_bit == twb_pkg::BIT_END) begin
          v.s_bit = 4'h0;
          v.s_low = 1'b0;
          if ((r.s_st == twb_pkg::twb_s_addr && r.sl_rw) ||
              (r.s_st == twb_pkg::twb_s_tx && !r.s_mack)) begin
            v.s_st = twb_pkg::twb_s_tx;
            v.s_wait = 1'b1;
          end else if (r.s_st == twb_pkg::twb_s_tx) begin
            v.s_st = twb_pkg::twb_s_ign;
          end else begin
            v.s_st = twb_pkg::twb_s_rx;
          end
        end else if (r.s_st == twb_pkg::twb_s_tx) begin
          v.s_low = ~r.s_tx[6];
          v.s_tx = {r.s_tx[6:0], 1'b1};
        end
      end
    end
    if (r.s_wait && sl_tx_valid) begin
      v.s_wait = 1'b0;
      v.s_tx = sl_tx_data;
      v.s_low = ~sl_tx_data[7];
      v.sl_tx_take = 1'b1;
    end

    v.scl_oe_n = ~(~v.m_scl | v.s_wait | r.s_wait);
    v.sda_oe_n = ~(~v.m_sda | v.s_low);
    v.cmd_ready = ((v.m_st == twb_m_idle) & ~v.busy & ~take) | (v.m_st == twb_m_hold & ~take);
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.scl_s1 <= twb_pkg::LINE_REL;
      r.scl_s2 <= twb_pkg::LINE_REL;
      r.sda_s1 <= twb_pkg::LINE_REL;
      r.sda_s2 <= twb_pkg::LINE_REL;
      r.scl_fl[4] <= twb_pkg::LINE_REL;
      r.sda_fl[4] <= twb_pkg::LINE_REL;
      r.scl_p <= twb_pkg::LINE_REL;
      r.sda_p <= twb_pkg::LINE_REL;
      r.m_scl <= twb_pkg::LINE_REL;
      r.m_sda <= twb_pkg::LINE_REL;
      r.scl_oe_n <= twb_pkg::LINE_REL;
      r.sda_oe_n <= twb_pkg::LINE_REL;
    end else begin
      r <= v;
    end
  end

  assign bus.dev_scl_o = 1'b0;
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_scl_oe_n = r.scl_oe_n;
  assign bus.dev_sda_oe_n = r.sda_oe_n;
  assign cmd_ready = r.cmd_ready;
  assign rsp_valid = r.rsp_valid;
  assign rsp_data = r.rsp_data;
  assign rsp_nack = r.rsp_nack;
  assign arb_lost = r.arb_lost;
  assign sl_tx_take = r.sl_tx_take;
  assign sl_rx_valid = r.sl_rx_valid;
  assign sl_rx_data = r.sl_rx_data;
  assign sl_match = r.sl_match;
  assign sl_rw = r.sl_rw;
  assign sl_gcall = r.sl_gcall;
  assign bus_busy = r.busy;
  assign start_seen = r.start_seen;
  assign stop_seen = r.stop_seen;
endmodule
`default_nettype wire

/* File: dv/twb_chk.sv */
/*
  assertions on the shared two-wire lines.
  assumes it sees the resolved lines and only the far-end enables of twb_if.
*/
`timescale 1ns/1ps
`default_nettype none
module twb_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic far_scl_oe_n,
  input wire logic far_sda_oe_n
);
  // ----------------------------------------
  // line checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_far_ack_low: assert property ($fell(far_sda_oe_n) |-> !scl)
    else $error("far end pulled sda with scl high");
  a_far_sda_rel: assert property ($rose(far_sda_oe_n) |-> !scl)
    else $error("far end released sda with scl high");
  a_ack_hold: assert property ($fell(far_sda_oe_n) |=> !far_sda_oe_n [*8])
    else $error("far end sda pull too short");
  a_far_scl_low: assert property ($fell(far_scl_oe_n) |-> !scl)
    else $error("far end pulled a high scl");
  a_stretch_end: assert property ($rose(far_scl_oe_n) |-> ##[0:400] scl)
    else $error("scl not released after stretch");
  a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
    else $error("scl high phase cut short");
  a_start_hold: assert property ($fell(sda) && scl |=> scl [*8])
    else $error("scl fell right after start");
  a_stop_hold: assert property ($rose(sda) && scl |=> scl [*8])
    else $error("scl fell right after stop");
  c_start: cover property ($fell(sda) && scl);
  c_stretch: cover property ($fell(far_scl_oe_n));
  c_far_ack: cover property ($fell(far_sda_oe_n));
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
/*
  testbench: device end as master against far end as slave.
  assumes both ends share twb_if and a 250 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys = 0, rst_n = 0, cmd_valid = 0, cmd_nack = 0, cmd_ready, rsp_valid, rsp_nack;
  logic [1:0] cmd_op = 0;
  logic [7:0] cmd_data = 0, rsp_data, rx_data, tx_data = 0, b, srx;
  logic [6:0] fa = 7'h20, own = 7'h70;
  logic gc = 0, stretch = 0, busy, fbusy, fack = 1, fmatch, gcall, arb;
  int errors = 0, checked = 0, rsp_cnt = 0, n, rc, seed = 32'haad9;
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (rsp_valid === 1'b1) rsp_cnt++;
  twb_if u_twb_if ();
  twb_dev_end u_twb_dev_end (.clk_sys(clk_sys), .rst_n(rst_n), .bus(u_twb_if.dev),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_nack(cmd_nack),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack),
    .arb_lost(arb), .own_addr(own), .gc_en(gc), .ack_en(1'b1), .sl_tx_data(tx_data),
    .sl_tx_valid(1'b1), .sl_tx_take(), .sl_rx_valid(), .sl_rx_data(srx), .sl_match(),
    .sl_rw(), .sl_gcall(gcall), .bus_busy(busy), .start_seen(), .stop_seen());
  twb_far_end u_twb_far_end (.clk_sys(clk_sys), .rst_n(rst_n), .bus(u_twb_if.far),
    .far_addr(fa), .gc_en(gc), .ack_en(fack), .stretch_req(stretch), .tx_data(tx_data),
    .tx_valid(1'b1), .tx_take(), .rx_valid(), .rx_data(rx_data), .addr_match(fmatch),
    .bus_busy(fbusy));
  twb_chk u_twb_chk (.clk_sys(clk_sys), .rst_n(rst_n), .scl(u_twb_if.scl),
    .sda(u_twb_if.sda), .far_scl_oe_n(u_twb_if.far_scl_oe_n),
    .far_sda_oe_n(u_twb_if.far_sda_oe_n));
  // ----------------------------------------
  // model, driver and checks
  // ----------------------------------------
  function automatic logic nack_of(input logic [7:0] a);
    return !((a[7:1] == fa) || (a == 8'h00 && gc));
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_rdy();
    n = 0;
    while (cmd_ready !== 1'b1 && n < 20000) begin
      @(posedge clk_sys);
      #1 n++;
    end
    if (n >= 20000) chk(0, 1);
  endtask
  task automatic cmd(input logic [1:0] op, input logic [7:0] d, input logic nk);
    wait_rdy();
    {cmd_valid, cmd_op, cmd_data, cmd_nack} = {1'b1, op, d, nk};
    @(posedge clk_sys);
    #1 cmd_valid = 0;
    wait_rdy();
  endtask
  task automatic wrap_up();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge clk_sys);
    errors++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    #1 rst_n = 1;
    fa = 7'h10 + 7'($random(seed) & 32'h3f);
    tx_data = 8'($random(seed)) & 8'h7f;
    b = 8'($random(seed));
    repeat (2) @(posedge clk_sys);
    #1 cmd(2'd0, {fa, 1'b0}, 1'b0);
    chk(rsp_nack, nack_of({fa, 1'b0}));
    chk(fmatch, 1);
    stretch = 1;
    fork
      begin
        repeat (1500) @(posedge clk_sys);
        #1 stretch = 0;
      end
    join_none
    cmd(2'd1, b, 1'b0);
    chk(rx_data, b);
    chk(rsp_nack, 0);
    fack = 0;
    cmd(2'd1, 8'(~b), 1'b0);
    chk(rx_data, 8'(~b));
    chk(rsp_nack, 1);
    fack = 1;
    cmd(2'd3, 8'h00, 1'b0);
    chk(fbusy, 0);
    $display("test 1 done");
    cmd(2'd0, {fa, 1'b0}, 1'b0);
    cmd(2'd0, {fa, 1'b1}, 1'b0);
    chk(fbusy, 1);
    cmd(2'd2, 8'h00, 1'b1);
    chk(rsp_data, tx_data);
    cmd(2'd3, 8'h00, 1'b0);
    $display("test 2 done");
    rc = rsp_cnt + 1;
    cmd(2'd0, {fa ^ 7'h01, 1'b0}, 1'b0);
    chk(rsp_nack, 1);
    chk(fmatch, 0);
    cmd(2'd1, 8'h55, 1'b0);
    chk(rsp_cnt, rc);
    cmd(2'd3, 8'h00, 1'b0);
    $display("test 3 done");
    gc = 1;
    b = 8'($random(seed));
    cmd(2'd0, 8'h01, 1'b0);
    chk(rsp_cnt, rc);
    cmd(2'd0, 8'h00, 1'b0);
    chk(rsp_nack, nack_of(8'h00));
    chk(gcall, 1);
    cmd(2'd1, b, 1'b0);
    chk(rx_data, b);
    chk(srx, b);
    cmd(2'd3, 8'h00, 1'b0);
    $display("test 4 done");
    cmd(2'd0, {fa, 1'b1}, 1'b0);
    {cmd_valid, cmd_op, cmd_data} = {1'b1, 2'd1, 8'hff};
    @(posedge clk_sys);
    #1 cmd_valid = 0;
    n = 0;
    while (arb !== 1'b1 && n < 2000) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk(arb, 1);
    chk(u_twb_if.dev_sda_oe_n, 1);
    rst_n = 0;
    repeat (20) @(posedge clk_sys);
    #1 rst_n = 1;
    repeat (2) @(posedge clk_sys);
    #1 chk(busy, 0);
    chk(cmd_ready, 1);
    $display("test 5 done");
    wrap_up();
  end
endmodule
`default_nettype wire
